/* File: adc_conversion_sequencer.sv */
// What this block does
// - Leaving reset, run a 3840-cycle calibration and show it on the calibration output.
// - After each conversion, post-calibrate the offset or one capacitor array bit.
// - On accepting start, raise sampling and busy together.
// - Drop sampling after sample-and-hold; keep busy until conversion ends.
// - At conversion end drop busy, raise result-valid, present the 12-bit result.
// - Result-valid holds until the next accepted start or a converter reset, then clears on a clock edge.
// - Result holds through the next conversion, updating only at conversion end, even when a same-cycle converter reset keeps result-valid low.
module adc_conversion_sequencer
(
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    input  wire logic                                i_converter_reset,
    input  wire logic                                i_conversion_start,
    input  wire logic [adc_seq_pkg::CH_W-1:0]        i_channel_select,
    input  wire logic                                i_comparator,
    output logic                                     o_calibrate,
    output logic                                     o_sample,
    output logic                                     o_busy,
    output logic                                     o_result_valid,
    output logic [adc_seq_pkg::RES_W-1:0]            o_result,
    output logic [adc_seq_pkg::CH_W-1:0]             o_channel,
    output logic [adc_seq_pkg::TRIM_W-1:0]           o_trim
);

    ////////////////////////////////////////////////////////////////////////////

    trim_mem_if tm();

    trim_mem u_trim_mem
    (
        .i_clk (i_clk),
        .port  (tm.mem)
    );

    ////////////////////////////////////////////////////////////////////////////

    adc_seq_pkg::seq_state_t             state_ff;
    adc_seq_pkg::seq_state_t             nxt_state;
    logic [adc_seq_pkg::CNT_W-1:0]       cnt_ff;
    logic [adc_seq_pkg::CNT_W-1:0]       nxt_cnt;
    logic [adc_seq_pkg::RES_W-1:0]       sar_ff;
    logic [adc_seq_pkg::RES_W-1:0]       nxt_sar;
    logic [adc_seq_pkg::RES_W-1:0]       result_ff;
    logic [adc_seq_pkg::RES_W-1:0]       nxt_result;
    logic [adc_seq_pkg::CH_W-1:0]        chan_ff;
    logic [adc_seq_pkg::CH_W-1:0]        nxt_chan;
    logic [3:0]                          slot_ff;
    logic [3:0]                          nxt_slot;
    logic [adc_seq_pkg::TRIM_W-1:0]      trim_ff;
    logic [adc_seq_pkg::TRIM_W-1:0]      nxt_trim;
    logic                                cal_ff;
    logic                                nxt_cal;
    logic                                sample_ff;
    logic                                nxt_sample;
    logic                                busy_ff;
    logic                                nxt_busy;
    logic                                valid_ff;
    logic                                nxt_valid;
    logic                                wr_en;
    logic [adc_seq_pkg::TRIM_W-1:0]      trim_adj;

    localparam logic [adc_seq_pkg::CNT_W-1:0] CAL_LAST =
        adc_seq_pkg::CNT_W'(adc_seq_pkg::CAL_CYCLES - 1);
    localparam logic [adc_seq_pkg::CNT_W-1:0] SAMPLE_LAST =
        adc_seq_pkg::CNT_W'(adc_seq_pkg::SAMPLE_CYCLES - 1);
    localparam logic [adc_seq_pkg::CNT_W-1:0] CONV_LAST =
        adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV_CYCLES - 1);
    localparam logic [adc_seq_pkg::CNT_W-1:0] POSTCAL_LAST =
        adc_seq_pkg::CNT_W'(adc_seq_pkg::POSTCAL_CYCLES - 1);

    // Comparator nudges the trim word of the current slot by one step
    assign trim_adj = i_comparator ? tm.rd_data + 8'h01 : tm.rd_data - 8'h01;

    assign tm.wr_en   = wr_en;
    assign tm.addr    = slot_ff;
    assign tm.wr_data = (state_ff == adc_seq_pkg::ST_CAL) ? adc_seq_pkg::TRIM_RESET : trim_adj;

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff + 12'h001;
        nxt_sar    = sar_ff;
        nxt_result = result_ff;
        nxt_chan   = chan_ff;
        nxt_slot   = slot_ff;
        nxt_trim   = trim_ff;
        nxt_cal    = cal_ff;
        nxt_sample = sample_ff;
        nxt_busy   = busy_ff;
        nxt_valid  = valid_ff;
        wr_en      = 1'b0;
        case (state_ff)
            adc_seq_pkg::ST_CAL:
            begin
                // Seed every trim slot while the fixed calibration runs
                wr_en   = 1'b1;
                nxt_slot = (slot_ff == adc_seq_pkg::TRIM_SLOT_LAST) ? 4'h0 : slot_ff + 4'h1;
                if (cnt_ff == CAL_LAST)
                begin
                    nxt_state = adc_seq_pkg::ST_IDLE;
                    nxt_cal   = 1'b0;
                    nxt_slot  = 4'h0;
                    nxt_cnt   = 12'h000;
                end
            end
            adc_seq_pkg::ST_IDLE:
            begin
                nxt_cnt = 12'h000;
                // Starts outside idle are dropped rather than queued
                if (i_conversion_start)
                begin
                    nxt_state  = adc_seq_pkg::ST_SAMPLE;
                    nxt_sample = 1'b1;
                    nxt_busy   = 1'b1;
                    nxt_valid  = 1'b0;
                    nxt_chan   = i_channel_select;
                    nxt_sar    = 12'h000;
                end
            end
            adc_seq_pkg::ST_SAMPLE:
            begin
                if (cnt_ff == SAMPLE_LAST)
                begin
                    nxt_state  = adc_seq_pkg::ST_CONVERT;
                    nxt_sample = 1'b0;
                    nxt_cnt    = 12'h000;
                end
            end
            adc_seq_pkg::ST_CONVERT:
            begin
                // One bit decided per cycle, MSB first; final cycle loads result
                if (cnt_ff < 12'h00c)
                begin
                    nxt_sar[4'hb - cnt_ff[3:0]] = i_comparator;
                end
                if (cnt_ff == CONV_LAST)
                begin
                    nxt_state  = adc_seq_pkg::ST_POSTCAL;
                    nxt_busy   = 1'b0;
                    nxt_valid  = 1'b1;
                    nxt_result = sar_ff;
                    nxt_cnt    = 12'h000;
                end
            end
            adc_seq_pkg::ST_POSTCAL:
            begin
                // Read-modify-write of one trim slot per conversion
                if (cnt_ff == POSTCAL_LAST)
                begin
                    wr_en     = 1'b1;
                    nxt_trim  = trim_adj;
                    nxt_slot  = (slot_ff == adc_seq_pkg::TRIM_SLOT_LAST) ? 4'h0 : slot_ff + 4'h1;
                    nxt_state = adc_seq_pkg::ST_IDLE;
                    nxt_cnt   = 12'h000;
                end
            end
            default:
            begin
                nxt_state = adc_seq_pkg::ST_CAL;
                nxt_cnt   = 12'h000;
                nxt_cal   = 1'b1;
            end
        endcase
        // Converter reset restarts power-up calibration from scratch
        if (i_converter_reset)
        begin
            nxt_state  = adc_seq_pkg::ST_CAL;
            nxt_cnt    = 12'h000;
            nxt_cal    = 1'b1;
            nxt_sample = 1'b0;
            nxt_busy   = 1'b0;
            nxt_valid  = 1'b0;
            nxt_slot   = 4'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff  <= adc_seq_pkg::ST_CAL;
            cnt_ff    <= 12'h000;
            sar_ff    <= 12'h000;
            result_ff <= 12'h000;
            chan_ff   <= 5'h00;
            slot_ff   <= 4'h0;
            trim_ff   <= adc_seq_pkg::TRIM_RESET;
            cal_ff    <= 1'b1;
            sample_ff <= 1'b0;
            busy_ff   <= 1'b0;
            valid_ff  <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            sar_ff    <= nxt_sar;
            result_ff <= nxt_result;
            chan_ff   <= nxt_chan;
            slot_ff   <= nxt_slot;
            trim_ff   <= nxt_trim;
            cal_ff    <= nxt_cal;
            sample_ff <= nxt_sample;
            busy_ff   <= nxt_busy;
            valid_ff  <= nxt_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign o_calibrate    = cal_ff;
    assign o_sample       = sample_ff;
    assign o_busy         = busy_ff;
    assign o_result_valid = valid_ff;
    assign o_result       = result_ff;
    assign o_channel      = chan_ff;
    assign o_trim         = trim_ff;

endmodule

/* File: adc_conversion_sequencer_tb_top.sv */
module adc_conversion_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, conv_rst = 1'b0, start, comp;
    logic sample, busy, valid, cal;
    logic [4:0] ch_sel, chan;
    logic [11:0] result, captured, tgt;
    logic [7:0] trim, trim_tab [adc_seq_pkg::TRIM_DEPTH];
    logic comp_q;
    int slot;
    int failures = 0, n_checks = 0, cycles = 0, n;
    always #12.5 clk = ~clk;
    adc_conversion_sequencer u_adc_conversion_sequencer (.i_clk(clk), .i_rst(rst),
        .i_converter_reset(conv_rst), .i_conversion_start(start), .i_channel_select(ch_sel),
        .i_comparator(comp), .o_calibrate(cal), .o_sample(sample), .o_busy(busy),
        .o_result_valid(valid), .o_result(result), .o_channel(chan), .o_trim(trim));
    adc_fabric_model u_adc_fabric_model (.i_clk(clk), .i_sample(sample), .i_busy(busy),
        .i_result_valid(valid), .i_result(result), .o_start(start),
        .o_channel_select(ch_sel), .o_comparator(comp), .o_captured(captured));
    ////////////////////////////////////////
    task automatic chk(string name, logic [11:0] seen, logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            failures++;
            complete_run();
        end
    end
    // Each step ends just after an edge, so a count of zero adds no skew
    task automatic tick(int k);
        repeat (k)
        begin
            @(posedge clk);
            #1;
        end
    endtask
    // Comparator as the design saw it at the last edge
    always @(posedge clk)
        comp_q <= comp;
    function automatic logic [7:0] trim_next(logic [7:0] w, logic up);
        return up ? w + 8'h01 : w - 8'h01;
    endfunction
    function automatic int cal_len();
        return 3840;
    endfunction
    task automatic wait_cal();
        while (cal && n < 5000)
        begin
            tick(1);
            n++;
        end
        foreach (trim_tab[i])
            trim_tab[i] = adc_seq_pkg::TRIM_RESET;
        slot = 0;
        chk("cal_cycles", 12'(n), 12'(cal_len()));
    endtask
    // Rude mode pokes start while busy and again in post-calibration; both must be dropped
    task automatic conv(input logic [4:0] ch, input logic [11:0] t, input bit rude);
        logic [11:0] prev;
        logic [7:0] exp_trim;
        prev = result;
        u_adc_fabric_model.request(ch, t);
        chk("sample", sample, 1);
        chk("busy", busy, 1);
        chk("valid_low", valid, 0);
        chk("channel", chan, ch);
        if (rude)
        begin
            tick(1);
            u_adc_fabric_model.poke();
            tick(2);
        end
        else
            tick(4);
        chk("sample_end", sample, 0);
        chk("busy_mid", busy, 1);
        chk("result_held", result, prev);
        tick(13);
        chk("busy_end", busy, 0);
        chk("valid", valid, 1);
        chk("result", result, t);
        if (rude)
            u_adc_fabric_model.poke();
        else
            tick(1);
        chk("postcal_idle", busy, 0);
        chk("captured", captured, t);
        tick(1);
        exp_trim = trim_next(trim_tab[slot], comp_q);
        chk("trim", trim, exp_trim);
        trim_tab[slot] = exp_trim;
        slot = (slot == adc_seq_pkg::TRIM_DEPTH - 1) ? 0 : slot + 1;
    endtask
    initial
    begin
        void'($urandom(84951));
        tick(20);
        rst = 1'b0;
        u_adc_fabric_model.poke();
        chk("cal_refuse", busy, 0);
        n = 1;
        wait_cal();
        for (int i = 0; i < 10; i++)
        begin
            tgt = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            conv(5'($urandom), tgt, i[0]);
            tick($urandom_range(3, 0));
            chk("valid_hold", valid, 1);
        end
        conv_rst = 1'b1;
        tick(1);
        conv_rst = 1'b0;
        chk("recal", cal, 1);
        chk("valid_cleared", valid, 0);
        n = 0;
        wait_cal();
        conv(5'h1f, 12'ha5c, 1'b0);
        complete_run();
    end
endmodule

/* File: adc_fabric_model.sv */
module adc_fabric_model
(
    input  wire logic                          i_clk,
    input  wire logic                          i_sample,
    input  wire logic                          i_busy,
    input  wire logic                          i_result_valid,
    input  wire logic [adc_seq_pkg::RES_W-1:0] i_result,
    output logic                               o_start,
    output logic [adc_seq_pkg::CH_W-1:0]       o_channel_select,
    output logic                               o_comparator,
    output logic [adc_seq_pkg::RES_W-1:0]      o_captured
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [adc_seq_pkg::RES_W-1:0] target;
    int                            bit_ix;
    initial
    begin
        o_start = 1'b0;
        o_channel_select = 5'h00;
        o_comparator = 1'b0;
        o_captured = 12'h000;
        target = 12'h000;
        bit_ix = 0;
    end
    // Outside conversion the decision toggles so a stray sample cannot pass by luck
    always @(posedge i_clk)
    begin
        #1;
        if (i_busy && !i_sample && bit_ix < 12)
            o_comparator = target[11 - bit_ix];
        else
            o_comparator = ~o_comparator;
        bit_ix = (i_busy && !i_sample) ? bit_ix + 1 : 0;
    end
    always @(posedge i_clk)
        if (i_result_valid)
            o_captured <= i_result;
    task automatic poke();
        o_start = 1'b1;
        @(posedge i_clk);
        #1 o_start = 1'b0;
    endtask
    task automatic request(input logic [4:0] ch, input logic [11:0] tgt);
        target = tgt;
        o_channel_select = ch;
        poke();
        o_channel_select = ~ch;
    endtask
endmodule

/* File: adc_seq_chk.sv */
module adc_seq_chk
(
    input wire logic                          i_clk,
    input wire logic                          i_rst,
    input wire logic                          i_converter_reset,
    input wire logic                          i_conversion_start,
    input wire logic [adc_seq_pkg::CH_W-1:0]  i_channel_select,
    input wire logic                          o_calibrate,
    input wire logic                          o_sample,
    input wire logic                          o_busy,
    input wire logic                          o_result_valid,
    input wire logic [adc_seq_pkg::RES_W-1:0] o_result,
    input wire logic [adc_seq_pkg::CH_W-1:0]  o_channel
);
    logic        vld_ff;
    logic        vld2_ff;
    int unsigned cal_cnt_ff;
    logic        post_cal;
    logic        accept;
    // Post-calibration is invisible at the ports: it is the two cycles after valid rises
    assign post_cal = (o_result_valid && !vld_ff) || (vld_ff && !vld2_ff);
    assign accept = i_conversion_start && !o_calibrate && !o_busy && !post_cal
                    && !i_converter_reset;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            vld_ff     <= 1'b0;
            vld2_ff    <= 1'b0;
            cal_cnt_ff <= 0;
        end
        else
        begin
            vld_ff     <= o_result_valid;
            vld2_ff    <= vld_ff;
            cal_cnt_ff <= o_calibrate ? cal_cnt_ff + 1 : 0;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_cal_len: assert property ($fell(o_calibrate) |-> cal_cnt_ff == 3840)
        else $error("calibration length wrong");
    a_cal_quiet: assert property (o_calibrate |-> !o_busy && !o_sample)
        else $error("activity during calibration");
    a_start_pair: assert property (accept |=> o_sample && o_busy)
        else $error("sample and busy not raised together");
    a_chan_latch: assert property (accept |=> o_channel == $past(i_channel_select))
        else $error("channel not latched");
    a_sample_len: assert property ($rose(o_sample) |-> o_sample[*4] ##1 (!o_sample && o_busy))
        else $error("sample phase wrong");
    a_busy_end: assert property ($rose(o_busy) |-> ##16 o_busy ##1 (!o_busy && o_result_valid))
        else $error("conversion end wrong");
    a_valid_clear: assert property (accept |=> !o_result_valid)
        else $error("valid not cleared by start");
    a_valid_hold: assert property (o_result_valid && !accept && !i_converter_reset |=> o_result_valid)
        else $error("valid dropped early");
    a_result_hold: assert property (o_busy |-> $stable(o_result))
        else $error("result changed during conversion");
    a_start_refused: assert property (i_conversion_start && !accept |=> !$rose(o_busy))
        else $error("start taken when not idle");
    c_cal_done: cover property ($fell(o_calibrate));
    c_accept: cover property (accept);
    c_refused: cover property (i_conversion_start && !accept);
    c_valid: cover property ($rose(o_result_valid));
endmodule

bind adc_conversion_sequencer adc_seq_chk u_adc_seq_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_converter_reset(i_converter_reset), .i_conversion_start(i_conversion_start),
    .i_channel_select(i_channel_select), .o_calibrate(o_calibrate), .o_sample(o_sample),
    .o_busy(o_busy), .o_result_valid(o_result_valid), .o_result(o_result),
    .o_channel(o_channel));

/* File: adc_seq_pkg.sv */
package adc_seq_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned CAL_CYCLES       = 3840;
    localparam int unsigned SAMPLE_CYCLES    = 4;
    localparam int unsigned CONV_CYCLES      = 13;
    localparam int unsigned POSTCAL_CYCLES   = 2;
    localparam int unsigned CNT_W            = 12;

    // Widths
    localparam int unsigned CH_W             = 5;
    localparam int unsigned RES_W            = 12;
    localparam int unsigned TRIM_W           = 8;
    localparam int unsigned TRIM_DEPTH       = 13;
    localparam int unsigned TRIM_AW          = 4;

    // Post-calibration walks offset, then bits 0..11, then wraps
    localparam logic [3:0]  TRIM_SLOT_LAST   = 4'hc;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;

    typedef enum logic [2:0]
    {
        ST_CAL     = 3'b000,
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b011,
        ST_POSTCAL = 3'b100
    } seq_state_t;

endpackage

/* File: trim_mem.sv */
module trim_mem
(
    input  wire logic   i_clk,
    trim_mem_if.mem     port
);
    logic [adc_seq_pkg::TRIM_W-1:0] mem_ff [adc_seq_pkg::TRIM_DEPTH];
    logic [adc_seq_pkg::TRIM_W-1:0] rd_ff;

    // No reset on the array so it maps onto plain storage; the sequencer
    // rewrites every slot during power-up calibration before any use.
    always_ff @(posedge i_clk)
    begin
        if (port.wr_en)
        begin
            mem_ff[port.addr] <= port.wr_data;
        end
        rd_ff <= mem_ff[port.addr];
    end

    assign port.rd_data = rd_ff;
endmodule

/* File: trim_mem_if.sv */
interface trim_mem_if;
    logic                                   wr_en;
    logic [adc_seq_pkg::TRIM_AW-1:0]        addr;
    logic [adc_seq_pkg::TRIM_W-1:0]         wr_data;
    logic [adc_seq_pkg::TRIM_W-1:0]         rd_data;

    modport ctrl (output wr_en, output addr, output wr_data, input rd_data);
    modport mem  (input wr_en, input addr, input wr_data, output rd_data);
endinterface
